// *** src/sbr_pkg.sv ***
package sbr_pkg;
  // burst channel codes on the mux select pins
  localparam logic [1:0] MUX_BURST_A = 2'h0;
  localparam logic [1:0] MUX_BURST_B = 2'h1;
  localparam logic [1:0] MUX_BURST_C = 2'h3;
  localparam logic [1:0] MUX_BURST_D = 2'h2;
  // one-hot track-and-hold channel positions
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int CH_C = 2;
  localparam int CH_D = 3;
  localparam int NUM_CH = 4;
  // result width and conversion length
  localparam int RES_W = 9;
  localparam logic [8:0] RES_MAX = 9'h1FF;
  localparam int CONV_CLKS = 10;
  // conversion clock generated by the controller
  localparam int SYS_CLK_MHZ = 25;
  localparam int CONV_PERIOD_NS = 200;
  localparam int SYS_PERIOD_NS = 40;
  localparam int CONV_HALF_CYC = (CONV_PERIOD_NS / 2 + SYS_PERIOD_NS - 1)
    / SYS_PERIOD_NS;
  // power-down startup wait, rounded up
  localparam int PDN_WAKE_NS = 5000;
  localparam int PDN_WAKE_CYC = (PDN_WAKE_NS + SYS_PERIOD_NS - 1)
    / SYS_PERIOD_NS;
  localparam logic [3:0] CNT_W4_ONE = 4'h1;
  typedef enum logic [1:0] {
    SBR_IDLE = 2'b00,
    SBR_LOW = 2'b01,
    SBR_HIGH = 2'b11,
    SBR_DONE = 2'b10
  } sbr_ctl_e;
endpackage

// *** src/sbr_if.sv ***
`timescale 1ns/1ps
interface sbr_if;
  logic track_enable;
  logic sample_sel_hi;
  logic sample_sel_lo;
  logic mux_enable;
  logic mux_sel_hi;
  logic mux_sel_lo;
  logic conversion_clock;
  logic start;
  logic power_down_request;
  logic serial_result_o;
  logic serial_result_oe;
  // open collector: low while driven, pulled up otherwise
  wire serial_result = serial_result_oe ? serial_result_o : 1'b1;
  modport dev (
    input track_enable, sample_sel_hi, sample_sel_lo, mux_enable,
    input mux_sel_hi, mux_sel_lo, conversion_clock, start,
    input power_down_request,
    output serial_result_o, serial_result_oe
  );
  modport ctl (
    output track_enable, sample_sel_hi, sample_sel_lo, mux_enable,
    output mux_sel_hi, mux_sel_lo, conversion_clock, start,
    output power_down_request,
    input serial_result
  );
endinterface

// *** src/sbr_dev.sv ***
`timescale 1ns/1ps
module sbr_dev (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  sbr_if.dev bus,
  input wire logic [8:0] i_sample_a,
  input wire logic [8:0] i_sample_b,
  input wire logic [8:0] i_sample_c,
  input wire logic [8:0] i_sample_d,
  output logic [3:0] o_track,
  output logic [3:0] o_mux_route,
  output logic o_busy
);
  logic [3:0] track_ff, nxt_track;
  logic [3:0] route_ff, nxt_route;
  logic [8:0] held_ff [4];
  logic [8:0] nxt_held [4];
  logic [8:0] sar_ff, nxt_sar;
  logic [3:0] bit_ff, nxt_bit;
  logic clk_d_ff, nxt_clk_d;
  logic sdo_ff, nxt_sdo;
  logic busy_ff, nxt_busy;
  logic [8:0] adc_in;
  logic fall;

  // maps a two-bit select code to a one-hot channel
  function automatic logic [3:0] sel_onehot(input logic [1:0] code);
    logic [3:0] oh;
    oh = 4'h0;
    case (code)
      sbr_pkg::MUX_BURST_A: oh[sbr_pkg::CH_A] = 1'b1;
      sbr_pkg::MUX_BURST_B: oh[sbr_pkg::CH_B] = 1'b1;
      sbr_pkg::MUX_BURST_C: oh[sbr_pkg::CH_C] = 1'b1;
      default: oh[sbr_pkg::CH_D] = 1'b1;
    endcase
    return oh;
  endfunction

  assign fall = clk_d_ff & ~bus.conversion_clock;

  // converter input is the held value of the routed channel
  always_comb begin
    adc_in = 9'h000;
    for (int i = 0; i < sbr_pkg::NUM_CH; i++) begin
      if (route_ff[i]) begin
        adc_in = adc_in | held_ff[i];
      end
    end
  end

  // track/hold per channel and mux routing
  always_comb begin
    nxt_track = 4'h0;
    if (bus.track_enable) begin
      nxt_track = sel_onehot({bus.sample_sel_hi, bus.sample_sel_lo});
    end
    nxt_route = 4'h0;
    if (bus.mux_enable) begin
      nxt_route = sel_onehot({bus.mux_sel_hi, bus.mux_sel_lo});
    end
  end

  // tracking channels follow their input; others hold
  generate
    for (genvar g = 0; g < sbr_pkg::NUM_CH; g++) begin : g_th
      logic [8:0] src;
      assign src = (g == 0) ? i_sample_a : (g == 1) ? i_sample_b :
        (g == 2) ? i_sample_c : i_sample_d;
      always_comb begin
        nxt_held[g] = track_ff[g] ? src : held_ff[g];
      end
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          held_ff[g] <= 9'h000;
        end else begin
          held_ff[g] <= nxt_held[g];
        end
      end
    end
  endgenerate

  // successive approximation, one bit per falling edge
  always_comb begin
    nxt_clk_d = bus.conversion_clock;
    nxt_sar = sar_ff;
    nxt_bit = bit_ff;
    nxt_sdo = sdo_ff;
    nxt_busy = busy_ff;
    if (bus.power_down_request) begin
      // biased down: drop any conversion and let the line float high
      nxt_busy = 1'b0;
      nxt_sdo = 1'b1;
    end else if (fall) begin
      if (!busy_ff && bus.start) begin
        nxt_busy = 1'b1;
        nxt_sar = adc_in;
        nxt_bit = 4'h0;
      end else if (busy_ff) begin
        nxt_sdo = sar_ff[sbr_pkg::RES_W - 1];
        nxt_sar = {sar_ff[sbr_pkg::RES_W - 2:0], 1'b0};
        nxt_bit = bit_ff + sbr_pkg::CNT_W4_ONE;
        if (bit_ff == 4'(sbr_pkg::RES_W - 1)) begin
          nxt_busy = 1'b0;
        end
      end
    end
  end

  // registers of the track and routing group
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      track_ff <= 4'h0;
      route_ff <= 4'h0;
    end else begin
      track_ff <= nxt_track;
      route_ff <= nxt_route;
    end
  end

  // registers of the converter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sar_ff <= 9'h000;
      bit_ff <= 4'h0;
      clk_d_ff <= 1'b0;
      sdo_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      sar_ff <= nxt_sar;
      bit_ff <= nxt_bit;
      clk_d_ff <= nxt_clk_d;
      sdo_ff <= nxt_sdo;
      busy_ff <= nxt_busy;
    end
  end

  assign bus.serial_result_o = 1'b0;
  assign bus.serial_result_oe = ~sdo_ff; // open collector pulls low
  assign o_track = track_ff;
  assign o_mux_route = route_ff;
  assign o_busy = busy_ff;
endmodule

// *** src/sbr_ctl.sv ***
`timescale 1ns/1ps
// controller end: drives selects, clock and start, collects result
module sbr_ctl (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  sbr_if.ctl bus,
  input wire logic i_track,
  input wire logic [1:0] i_sample_sel,
  input wire logic i_power_down,
  input wire logic i_conv_req,
  input wire logic [1:0] i_mux_sel,
  output logic o_ready,
  output logic o_busy,
  output logic o_done,
  output logic [8:0] o_result
);
  sbr_pkg::sbr_ctl_e st_ff, nxt_st;
  logic [7:0] half_ff, nxt_half;
  logic [3:0] pulse_ff, nxt_pulse;
  logic [8:0] shift_ff, nxt_shift;
  logic [8:0] res_ff, nxt_res;
  logic [8:0] wake_ff, nxt_wake;
  logic [1:0] msel_ff, nxt_msel;
  logic cclk_ff, nxt_cclk;
  logic start_ff, nxt_start;
  logic men_ff, nxt_men;
  logic done_ff, nxt_done;
  logic trk_ff, nxt_trk;
  logic half_end;

  assign half_end = (half_ff == 8'(sbr_pkg::CONV_HALF_CYC - 1));

  // conversion sequencer; clock made by dividing the system clock
  always_comb begin
    nxt_st = st_ff;
    nxt_half = half_end ? 8'h00 : half_ff + 8'h01;
    nxt_pulse = pulse_ff;
    nxt_shift = shift_ff;
    nxt_res = res_ff;
    nxt_msel = msel_ff;
    nxt_cclk = cclk_ff;
    nxt_start = start_ff;
    nxt_men = men_ff;
    nxt_done = 1'b0;
    nxt_trk = i_track && !i_power_down && wake_ff == 9'h000;
    nxt_wake = i_power_down ? 9'(sbr_pkg::PDN_WAKE_CYC) :
      (wake_ff != 9'h000 ? wake_ff - 9'h001 : 9'h000);
    case (st_ff)
      sbr_pkg::SBR_IDLE: begin
        nxt_half = 8'h00;
        nxt_cclk = 1'b0;
        if (i_conv_req && o_ready) begin
          nxt_st = sbr_pkg::SBR_HIGH;
          nxt_msel = i_mux_sel;
          nxt_men = 1'b1;
          nxt_start = 1'b1;
          nxt_cclk = 1'b1;
          nxt_pulse = 4'h0;
          nxt_trk = 1'b0;
        end
      end
      sbr_pkg::SBR_HIGH: begin
        nxt_trk = 1'b0;
        if (half_end) begin
          nxt_cclk = 1'b0;
          nxt_st = sbr_pkg::SBR_LOW;
          if (pulse_ff > 4'h1) begin
            nxt_shift = {shift_ff[7:0], bus.serial_result};
          end
        end
      end
      sbr_pkg::SBR_LOW: begin
        nxt_trk = 1'b0;
        if (half_end) begin
          nxt_pulse = pulse_ff + 4'h1;
          nxt_start = 1'b0;
          if (pulse_ff == 4'(sbr_pkg::CONV_CLKS - 1)) begin
            nxt_st = sbr_pkg::SBR_DONE;
          end else begin
            nxt_cclk = 1'b1;
            nxt_st = sbr_pkg::SBR_HIGH;
          end
        end
      end
      sbr_pkg::SBR_DONE: begin
        // last bit valid after tenth falling edge
        nxt_res = {shift_ff[7:0], bus.serial_result};
        nxt_men = 1'b0;
        nxt_done = 1'b1;
        nxt_st = sbr_pkg::SBR_IDLE;
      end
      default: nxt_st = sbr_pkg::SBR_IDLE;
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_ff <= sbr_pkg::SBR_IDLE;
      half_ff <= 8'h00;
      pulse_ff <= 4'h0;
      shift_ff <= 9'h000;
      res_ff <= 9'h000;
      wake_ff <= 9'(sbr_pkg::PDN_WAKE_CYC);
      msel_ff <= 2'h0;
      cclk_ff <= 1'b0;
      start_ff <= 1'b0;
      men_ff <= 1'b0;
      done_ff <= 1'b0;
      trk_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      half_ff <= nxt_half;
      pulse_ff <= nxt_pulse;
      shift_ff <= nxt_shift;
      res_ff <= nxt_res;
      wake_ff <= nxt_wake;
      msel_ff <= nxt_msel;
      cclk_ff <= nxt_cclk;
      start_ff <= nxt_start;
      men_ff <= nxt_men;
      done_ff <= nxt_done;
      trk_ff <= nxt_trk;
    end
  end

  assign bus.conversion_clock = cclk_ff;
  assign bus.start = start_ff;
  assign bus.mux_enable = men_ff;
  assign bus.mux_sel_hi = msel_ff[1];
  assign bus.mux_sel_lo = msel_ff[0];
  assign bus.track_enable = trk_ff;
  assign bus.sample_sel_hi = i_sample_sel[1];
  assign bus.sample_sel_lo = i_sample_sel[0];
  assign bus.power_down_request = i_power_down;
  assign o_ready = (st_ff == sbr_pkg::SBR_IDLE) && (wake_ff == 9'h000);
  assign o_busy = (st_ff != sbr_pkg::SBR_IDLE);
  assign o_done = done_ff;
  assign o_result = res_ff;
endmodule

// *** dv/sbr_properties.sv ***
`timescale 1ns/1ps
// watches the link between the controller end and the device end
module sbr_props (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic track_enable,
  input wire logic mux_enable,
  input wire logic mux_sel_hi,
  input wire logic mux_sel_lo,
  input wire logic conversion_clock,
  input wire logic start,
  input wire logic power_down_request,
  input wire logic serial_result_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic clk_d_ff;
  logic nxt_clk_d;
  logic [3:0] falls_ff;
  logic [3:0] nxt_falls;
  // count conversion clock falls inside one mux enable window
  always_comb begin
    nxt_clk_d = conversion_clock;
    nxt_falls = falls_ff;
    if (!mux_enable) begin
      nxt_falls = 4'h0;
    end else if (clk_d_ff && !conversion_clock) begin
      nxt_falls = falls_ff + 4'h1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    clk_d_ff <= nxt_clk_d;
    falls_ff <= nxt_falls;
  end
  // link relations
  oe_on_fall_a: assert property (
    $changed(serial_result_oe) |-> !conversion_clock)
    else $error("result line moved while clock high");
  start_width_a: assert property (
    $rose(start) |-> start [*6] ##1 !start)
    else $error("start not one clock period long");
  start_fall_a: assert property (
    $rose(start) |-> conversion_clock [*3] ##1 (!conversion_clock && start))
    else $error("no falling edge while start high");
  mux_first_a: assert property (start |-> mux_enable)
    else $error("start without mux enable");
  mux_hold_a: assert property ($fell(mux_enable) |-> falls_ff == 4'hA)
    else $error("mux enable dropped before ten clocks");
  src_fixed_a: assert property (
    mux_enable && $past(mux_enable) |->
    $stable({mux_sel_hi, mux_sel_lo}) && !track_enable)
    else $error("converter input changed mid conversion");
  clk_idle_a: assert property (!mux_enable |-> !conversion_clock)
    else $error("conversion clock runs outside frame");
  pdn_nostart_a: assert property (power_down_request |-> !start)
    else $error("start during power down");
  cover property ($fell(mux_enable));
  cover property ($rose(start));
  cover property ($fell(power_down_request));
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_track = 1'b0;
  logic [1:0] i_sample_sel = 2'h0;
  logic i_power_down = 1'b0;
  logic i_conv_req = 1'b0;
  logic [1:0] i_mux_sel = 2'h0;
  logic o_ready, o_busy, c_busy, o_done;
  logic [8:0] o_result;
  logic [3:0] o_track, o_mux_route;
  logic [8:0] smp [4] = '{9'h000, sbr_pkg::RES_MAX, 9'h15E, 9'h0A2};
  logic [8:0] held [4];
  logic [1:0] code [4] = '{sbr_pkg::MUX_BURST_A, sbr_pkg::MUX_BURST_B,
    sbr_pkg::MUX_BURST_C, sbr_pkg::MUX_BURST_D};
  logic [8:0] wire_bits = 9'h000;
  int num_errors = 0;
  int checks_done = 0;
  int n;
  sbr_if bus ();
  sbr_dev sbr_dev_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .bus(bus.dev), .i_sample_a(smp[0]), .i_sample_b(smp[1]),
    .i_sample_c(smp[2]), .i_sample_d(smp[3]), .o_track(o_track),
    .o_mux_route(o_mux_route), .o_busy(o_busy));
  sbr_ctl sbr_ctl_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .bus(bus.ctl), .i_track(i_track), .i_sample_sel(i_sample_sel),
    .i_power_down(i_power_down), .i_conv_req(i_conv_req),
    .i_mux_sel(i_mux_sel), .o_ready(o_ready), .o_busy(c_busy),
    .o_done(o_done), .o_result(o_result));
  sbr_props sbr_props_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .track_enable(bus.track_enable), .mux_enable(bus.mux_enable),
    .mux_sel_hi(bus.mux_sel_hi), .mux_sel_lo(bus.mux_sel_lo),
    .conversion_clock(bus.conversion_clock), .start(bus.start),
    .power_down_request(bus.power_down_request),
    .serial_result_oe(bus.serial_result_oe));
  // system clock
  always #20 i_sys_clk = ~i_sys_clk;
  // collect one wire bit per falling edge, last one at frame end
  always @(negedge bus.conversion_clock or negedge bus.mux_enable) begin
    wire_bits = {wire_bits[7:0], bus.serial_result};
  end
  // compare and count
  task chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // verdict and end of run
  task test_done;
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // track mode for every sample code, then release to hold
  task t_track;
    for (n = 0; n < 400 && o_ready !== 1'b1; n++) @(negedge i_sys_clk);
    chk({8'h00, o_ready}, 9'h001, "wake at start");
    i_track = 1'b1;
    for (int k = 0; k < 4; k++) begin
      i_sample_sel = code[k];
      repeat (4) @(negedge i_sys_clk);
      chk({5'h00, o_track}, {5'h00, 4'h1 << k}, "track chan");
    end
    i_track = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    chk({5'h00, o_track}, 9'h000, "hold");
    // held values must survive new levels on the inputs
    held = smp;
    smp = '{9'h0FF, 9'h000, 9'h0A1, 9'h15D};
  endtask
  // one conversion on each mux code, boundary values among them
  task t_conv;
    for (int k = 0; k < 4; k++) begin
      for (n = 0; n < 400 && o_ready !== 1'b1; n++) @(negedge i_sys_clk);
      chk({8'h00, o_ready}, 9'h001, "ready");
      i_mux_sel = code[k];
      i_conv_req = 1'b1;
      @(negedge i_sys_clk);
      i_conv_req = 1'b0;
      for (n = 0; n < 20 && o_busy !== 1'b1; n++) @(negedge i_sys_clk);
      chk({8'h00, o_busy}, 9'h001, "conversion start");
      repeat (3) @(negedge i_sys_clk);
      chk({5'h00, o_mux_route}, {5'h00, 4'h1 << k}, "route");
      for (n = 0; n < 200 && o_done !== 1'b1; n++) @(negedge i_sys_clk);
      chk({8'h00, o_done}, 9'h001, "done");
      chk(o_result, held[k], "result");
      chk(wire_bits, held[k], "wire order");
    end
  endtask
  // requests refused in power down, wake wait afterwards
  task t_pdn;
    i_power_down = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    i_conv_req = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    i_conv_req = 1'b0;
    chk({7'h00, o_ready, c_busy}, 9'h000, "pdn refuse");
    chk({8'h00, bus.serial_result}, 9'h001, "line released");
    i_power_down = 1'b0;
    for (n = 0; n < 400 && o_ready !== 1'b1; n++) @(negedge i_sys_clk);
    chk({8'h00, n >= sbr_pkg::PDN_WAKE_CYC &&
      n <= sbr_pkg::PDN_WAKE_CYC + 1}, 9'h001, "wake wait");
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    @(negedge i_sys_clk);
    chk({8'h00, bus.serial_result}, 9'h001, "idle line");
    t_track();
    t_conv();
    t_pdn();
    t_conv();
    test_done();
  end
  // watchdog
  initial begin
    #(40 * 20000);
    num_errors++;
    test_done();
  end
endmodule
